// >>> src/roa_arbiter.sv
// Output port arbitration, address discard and silence disable for an 11-port router
`timescale 1ns/1ps
`include "roa_params.svh"

// How it works
// - Owned silent link is disabled after timeout with no data or end-of-packet sent.
// - Silence disable acts only while router timeouts are enabled.
// - Links started remotely or carrying received packet data are never disabled.
// - Bad-address packets are spilled; input is free once their end arrives.
// - Equal priority: next higher-numbered requester after last holder wins, modulo ports.
// - The last holder of an output at a priority level gets lowest precedence at that level next time.
// - Waiting high-priority packets always beat waiting low-priority ones.
// - Priority comes from the logical address at the packet head.
// - An output stays granted until the holder's whole packet has passed.
// - Command and reply packets get no special treatment in arbitration.
// - Low-priority pointer moves only on low-priority grants.
// - Starved low-priority packets never time out.
// - Round-robin covers input ports zero to ten, then wraps.
// - Control register holds timeout, silence, start-on-request and self-address enables.
// - Silence enable reset value comes from an active-low strap pin.
// - Start-on-request: request to a stopped link asks to connect, then forwards.
// - Timeout enable is bit 0 of the control register.
module roa_arbiter
    import roa_pkg::*;
(
    // Clock and reset
    input  wire logic         CLK_I,
    input  wire logic         NRST_I,
    // Register port
    input  wire logic [7:0]   ADDR_I,
    input  wire logic [31:0]  WDATA_I,
    input  wire logic         WR_I,
    input  wire logic         RD_I,
    output logic      [31:0]  RDATA_O,
    // Strap pin, active low
    input  wire logic         POR_SILENCE_N_I,
    // Input port requests, one field per input
    input  wire logic [10:0]  REQ_I,
    input  wire logic [43:0]  REQ_DEST_I,
    input  wire logic [87:0]  REQ_ADDR_I,
    input  wire logic [10:0]  EOP_I,
    // Input port answers
    output logic      [10:0]  GRANT_O,
    output logic      [10:0]  SPILL_O,
    // Link ports, one per output
    input  wire logic [10:0]  LINK_RUN_I,
    input  wire logic [10:0]  LINK_OWN_I,
    input  wire logic [10:0]  TX_CHAR_I,
    input  wire logic [10:0]  RX_DATA_I,
    output logic      [10:0]  CONNECT_O,
    output logic      [10:0]  LINK_DIS_O,
    // Interrupt
    output logic              IRQ_O
);

    // ==========================================================
    // Register file and strap capture
    logic [3:0]               ctrl_r, ctrl_nxt;
    roa_cnt_t                 tmo_r, tmo_nxt;
    logic [7:0]               prio_r, prio_nxt;
    logic [21:0]              stat_r, stat_nxt;
    logic [21:0]              mask_r, mask_nxt;
    logic [31:0]              rdata_nxt;
    logic                     irq_nxt;
    logic                     strap_s1_r, strap_s2_r;
    roa_strap_t               st_r, st_nxt;
    logic [21:0]              events;
    logic [10:0]              busy_v;
    logic [10:0]              dis_nxt;
    logic [10:0]              spill_start;
    logic                     tmo_en, sil_en, sor_en, self_en;

    assign tmo_en  = ctrl_r[`ROA_BIT_TMO_EN];
    assign sil_en  = ctrl_r[`ROA_BIT_SIL_EN];
    assign sor_en  = ctrl_r[`ROA_BIT_SOR_EN];
    assign self_en = ctrl_r[`ROA_BIT_SELF_EN];
    assign events  = {spill_start, dis_nxt};

    // Next register values; hardware set wins over a write-one clear
    always_comb begin
        ctrl_nxt  = ctrl_r;
        tmo_nxt   = tmo_r;
        prio_nxt  = prio_r;
        mask_nxt  = mask_r;
        stat_nxt  = stat_r;
        st_nxt    = st_r;
        rdata_nxt = 32'h0000_0000;
        case (st_r)
            ROA_ST_WAIT0: st_nxt = ROA_ST_WAIT1;
            ROA_ST_WAIT1: begin
                st_nxt = ROA_ST_DONE;
                ctrl_nxt[`ROA_BIT_SIL_EN] = ~strap_s2_r;
            end
            ROA_ST_DONE:  st_nxt = ROA_ST_DONE;
            default:      st_nxt = ROA_ST_DONE;
        endcase
        if (WR_I) begin
            case (ADDR_I)
                `ROA_OFF_CTRL: begin
                    ctrl_nxt = WDATA_I[3:0];
                    tmo_nxt  = WDATA_I[31:`ROA_TMO_LSB];
                end
                `ROA_OFF_PRIO: prio_nxt = WDATA_I[7:0];
                `ROA_OFF_STAT: stat_nxt = stat_r & ~WDATA_I[21:0];
                `ROA_OFF_MASK: mask_nxt = WDATA_I[21:0];
                default: ;
            endcase
        end
        stat_nxt = stat_nxt | events;
        if (RD_I) begin
            case (ADDR_I)
                `ROA_OFF_CTRL: rdata_nxt = {tmo_r, 12'h000, ctrl_r};
                `ROA_OFF_PRIO: rdata_nxt = {24'h00_0000, prio_r};
                `ROA_OFF_STAT: rdata_nxt = {10'h000, stat_r};
                `ROA_OFF_MASK: rdata_nxt = {10'h000, mask_r};
                `ROA_OFF_BUSY: rdata_nxt = {21'h00_0000, busy_v};
                default:       rdata_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    // Register stage; the strap is only sampled through the two-flop chain
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl_r     <= `ROA_CTRL_RST;
            tmo_r      <= `ROA_TMO_RST;
            prio_r     <= `ROA_PRIO_RST;
            stat_r     <= 22'h00_0000;
            mask_r     <= 22'h00_0000;
            RDATA_O    <= 32'h0000_0000;
            IRQ_O      <= 1'b0;
            st_r       <= ROA_ST_WAIT0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            tmo_r      <= tmo_nxt;
            prio_r     <= prio_nxt;
            stat_r     <= stat_nxt;
            mask_r     <= mask_nxt;
            RDATA_O    <= rdata_nxt;
            IRQ_O      <= irq_nxt;
            st_r       <= st_nxt;
        end
    end

    // Strap chain keeps sampling through reset, so the pin level has settled at release
    always_ff @(posedge CLK_I) begin
        strap_s1_r <= POR_SILENCE_N_I;
        strap_s2_r <= strap_s1_r;
    end

    irq_level_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        ##1 (IRQ_O == |($past(stat_nxt) & $past(mask_nxt))))
        else $error("Interrupt does not follow masked status");

    // ==========================================================
    // Request decode per input
    // Round-robin pick: nearest set bit after last, last itself comes last
    function automatic roa_port_t rr_pick(input logic [10:0] v, input roa_port_t last);
        logic [4:0] s;
        roa_port_t  pick;
        pick = last;
        for (int k = `ROA_NPORT; k >= 1; k--) begin
            s = {1'b0, last} + 5'(k);
            if (s >= 5'(`ROA_NPORT)) s = s - 5'(`ROA_NPORT);
            if (v[s[3:0]]) pick = s[3:0];
        end
        return pick;
    endfunction

    logic [10:0]              req_hi;
    logic [10:0]              bad_addr;
    logic [10:0]              spill_nxt;
    logic [10:0]              grant_nxt;
    logic [10:0]              newg [`ROA_NPORT];
    logic [10:0]              reqv [`ROA_NPORT];

    // Classify each head: priority from logical address, discard on bad address
    always_comb begin
        for (int i = 0; i < `ROA_NPORT; i++) begin
            req_hi[i]   = REQ_ADDR_I[i*8 +: 8] >= prio_r;
            bad_addr[i] = (REQ_DEST_I[i*4 +: 4] > `ROA_LAST_PORT)
                        || ((REQ_DEST_I[i*4 +: 4] == 4'(i)) && !self_en)
                        || (!LINK_RUN_I[REQ_DEST_I[i*4 +: 4] % 11] && !sor_en);
            spill_start[i] = REQ_I[i] && bad_addr[i] && !SPILL_O[i] && !GRANT_O[i];
            // Free again once the spilled packet's end marker is seen
            spill_nxt[i] = (SPILL_O[i] && !EOP_I[i]) || spill_start[i];
        end
        // Every packet type follows the same path; no type bypasses arbitration
        grant_nxt = GRANT_O & ~EOP_I;
        for (int o = 0; o < `ROA_NPORT; o++) begin
            grant_nxt = grant_nxt | newg[o];
        end
    end

    // ==========================================================
    // Per output: arbiter, pointers and silence counter
    for (genvar o = 0; o < `ROA_NPORT; o++) begin : g_out
        logic      busy_r, busy_nxt;
        roa_port_t own_r, own_nxt;
        roa_port_t phi_r, phi_nxt;
        roa_port_t plo_r, plo_nxt;
        roa_cnt_t  cnt_r, cnt_nxt;
        logic      rxs_r, rxs_nxt;
        logic      con_nxt;
        logic [10:0] vh, vl, want;
        roa_port_t pick;

        // Arbitration only when the output is free, i.e. at a packet boundary
        always_comb begin
            for (int i = 0; i < `ROA_NPORT; i++) begin
                want[i] = REQ_I[i] && !bad_addr[i] && !SPILL_O[i] && !GRANT_O[i]
                        && (REQ_DEST_I[i*4 +: 4] == 4'(o));
            end
            reqv[o]  = want & {11{LINK_RUN_I[o]}};
            vh       = reqv[o] & req_hi;
            vl       = reqv[o] & ~req_hi;
            busy_nxt = busy_r;
            own_nxt  = own_r;
            phi_nxt  = phi_r;
            plo_nxt  = plo_r;
            newg[o]  = 11'h000;
            pick     = 4'h0;
            if (busy_r) begin
                if (EOP_I[own_r]) busy_nxt = 1'b0;
            end else if (|vh) begin
                pick     = rr_pick(vh, phi_r);
                phi_nxt  = pick;
            end else if (|vl) begin
                pick     = rr_pick(vl, plo_r);
                plo_nxt  = pick;
            end
            if (!busy_r && (|reqv[o])) begin
                busy_nxt = 1'b1;
                own_nxt  = pick;
                newg[o]  = 11'h001 << pick;
            end
            // Stopped link with a waiting packet asks to connect
            con_nxt = sor_en && !LINK_RUN_I[o] && (|want);
            // Silence counting; no waiting timer exists for starved packets
            rxs_nxt = LINK_RUN_I[o] && (rxs_r || RX_DATA_I[o]);
            cnt_nxt = (cnt_r != tmo_r) ? cnt_r + 16'h0001 : cnt_r;
            dis_nxt[o] = (cnt_r == tmo_r) && tmo_en && sil_en
                       && LINK_OWN_I[o] && !rxs_r && LINK_RUN_I[o];
            if (!LINK_RUN_I[o] || TX_CHAR_I[o] || dis_nxt[o]) cnt_nxt = 16'h0000;
        end

        always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                busy_r        <= 1'b0;
                own_r         <= 4'h0;
                phi_r         <= `ROA_LAST_PORT;
                plo_r         <= `ROA_LAST_PORT;
                cnt_r         <= 16'h0000;
                rxs_r         <= 1'b0;
                CONNECT_O[o]  <= 1'b0;
                LINK_DIS_O[o] <= 1'b0;
            end else begin
                busy_r        <= busy_nxt;
                own_r         <= own_nxt;
                phi_r         <= phi_nxt;
                plo_r         <= plo_nxt;
                cnt_r         <= cnt_nxt;
                rxs_r         <= rxs_nxt;
                CONNECT_O[o]  <= con_nxt;
                LINK_DIS_O[o] <= dis_nxt[o];
            end
        end
        assign busy_v[o] = busy_r;

        grant_hold_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            busy_r && !EOP_I[own_r] |=> busy_r && (own_r == $past(own_r)))
            else $error("Output released before end of packet");
        hi_first_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            !busy_r && (|vh) |=> busy_r && ((($past(vh) >> own_r) & 11'h001) == 11'h001))
            else $error("Low priority granted over high priority");
        rr_ptr_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            !busy_r && (|vl) && !(|vh) |=> (plo_r == own_r) && (phi_r == $past(phi_r)))
            else $error("Low priority pointer not moved to grantee");
        silence_gate_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            LINK_DIS_O[o] |-> $past(tmo_en) && $past(sil_en))
            else $error("Link disabled with timeouts or silence mode off");
        remote_keep_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            LINK_DIS_O[o] |-> $past(LINK_OWN_I[o]) && !$past(rxs_r))
            else $error("Remote or receiving link disabled");
        silence_time_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
            LINK_DIS_O[o] |-> $past(cnt_r) == $past(tmo_r))
            else $error("Link disabled before the silence period");
    end

    // ==========================================================
    // Input answers
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            GRANT_O <= 11'h000;
            SPILL_O <= 11'h000;
        end else begin
            GRANT_O <= grant_nxt;
            SPILL_O <= spill_nxt;
        end
    end

    spill_end_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (SPILL_O & EOP_I) != 11'h000 |=> (SPILL_O & $past(SPILL_O & EOP_I)) == 11'h000)
        else $error("Spill not ended by end marker");
    no_bad_grant_a: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        (GRANT_O & SPILL_O) == 11'h000)
        else $error("Spilling input was granted");

endmodule

// >>> include/roa_params.svh
// Register offsets, field positions, reset values and sizes for the output port arbiter
`ifndef ROA_PARAMS_SVH
`define ROA_PARAMS_SVH
`define ROA_NPORT         11
`define ROA_LAST_PORT     4'h0A
`define ROA_OFF_CTRL      8'h00
`define ROA_OFF_PRIO      8'h04
`define ROA_OFF_STAT      8'h08
`define ROA_OFF_MASK      8'h0C
`define ROA_OFF_BUSY      8'h10
`define ROA_BIT_TMO_EN    0
`define ROA_BIT_SIL_EN    1
`define ROA_BIT_SOR_EN    2
`define ROA_BIT_SELF_EN   3
`define ROA_TMO_LSB       16
`define ROA_CTRL_RST      4'h0
`define ROA_TMO_RST       16'hFFFF
`define ROA_PRIO_RST      8'h40
`define ROA_STAT_W        22
`define ROA_ERR_LSB       11
`endif

// >>> include/roa_pkg.sv
// Types shared by the output port arbiter
package roa_pkg;
    typedef logic [3:0]  roa_port_t;
    typedef logic [15:0] roa_cnt_t;
    // Gray-coded walk of the strap capture after reset release
    typedef enum logic [1:0] {
        ROA_ST_WAIT0 = 2'b00,
        ROA_ST_WAIT1 = 2'b01,
        ROA_ST_DONE  = 2'b11
    } roa_strap_t;
endpackage

// >>> test/roa_src_model.sv
// Model of the router input ports that feed packets to the arbiter
`timescale 1ns/1ps
module roa_src_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // New packet heads and their length
    input  wire logic [10:0] post_i,
    input  wire logic [7:0]  len_i,
    // Arbiter answers
    input  wire logic [10:0] grant_i,
    input  wire logic [10:0] spill_i,
    // Heads waiting and packet ends
    output logic      [10:0] req_o,
    output logic      [10:0] eop_o
);
    logic [7:0]  left_r [11];
    logic [10:0] busy_r;

    // A head stays up until taken; each packet ends exactly once, len_i cycles on
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_o  <= '0;
            eop_o  <= '0;
            busy_r <= '0;
            for (int i = 0; i < 11; i++) left_r[i] <= 8'h00;
        end else begin
            req_o <= (req_o | post_i) & ~(grant_i | spill_i);
            for (int i = 0; i < 11; i++) begin
                eop_o[i] <= 1'b0;
                if (!(grant_i[i] | spill_i[i])) begin
                    busy_r[i] <= 1'b0;
                end else if (!busy_r[i]) begin
                    busy_r[i] <= 1'b1;
                    left_r[i] <= len_i;
                end else if (left_r[i] != 8'h00) begin
                    // End marker only once the whole packet has gone by
                    left_r[i] <= left_r[i] - 8'h01;
                    eop_o[i]  <= (left_r[i] == 8'h01);
                end
            end
        end
    end
endmodule

// >>> test/router_output_port_arbiter_test.sv
// Self-checking bench for the output port arbiter
`timescale 1ns/1ps
`include "roa_params.svh"
module router_output_port_arbiter_test import roa_pkg::*; ;
    logic        clk, nrst, wr, rd, rd_d, strap;
    logic [7:0]  addr, len, ua;
    logic [31:0] wdata;
    wire  [31:0] rdata;
    logic [43:0] dest, dest_n;
    logic [87:0] laddr, laddr_n;
    logic [10:0] post, pend, run, own, txc, rxd, prev_g, prev_s, seen, rxm;
    wire  [10:0] req, eop, grant, spill, conn, dis;
    wire         irq;
    roa_port_t   exp_grant[$], exp_spill[$];
    logic [31:0] exp_rd[$];
    int          bad_count, comparisons;

    roa_arbiter i_dut (.CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .POR_SILENCE_N_I(strap), .REQ_I(req), .REQ_DEST_I(dest),
        .REQ_ADDR_I(laddr), .EOP_I(eop), .GRANT_O(grant), .SPILL_O(spill), .LINK_RUN_I(run),
        .LINK_OWN_I(own), .TX_CHAR_I(txc), .RX_DATA_I(rxd), .CONNECT_O(conn),
        .LINK_DIS_O(dis), .IRQ_O(irq));
    roa_src_model i_src (.clk_i(clk), .nrst_i(nrst), .post_i(post), .len_i(len),
        .grant_i(grant), .spill_i(spill), .req_o(req), .eop_o(eop));

    // ==========================================
    // Clock, random packet lengths, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) len <= 8'(1 + $urandom % 6);
    initial begin
        #200_000;
        bad_count++;
        tally_and_finish();
    end

    // ==========================================
    // Compare and report
    task chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task chk_port(input string what, input roa_port_t e, input roa_port_t g);
        chk_word(what, {28'h000_0000, e}, {28'h000_0000, g});
    endtask
    task tally_and_finish;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Watcher: every new grant, spill or read answer takes the oldest note
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk) begin
        if (rd_d) chk_word("read data", exp_rd.pop_front(), rdata);
        for (int i = 0; i < 11; i++) begin
            if (grant[i] && !prev_g[i]) chk_port("grant", exp_grant.pop_front(), 4'(i));
            if (spill[i] && !prev_s[i]) chk_port("spill", exp_spill.pop_front(), 4'(i));
        end
        // All contended packets share one output, so two grants at once is wrong
        chk_word("grant overlap", 32'h0, 32'($countones(grant) > 1));
        prev_g <= grant;
        prev_s <= spill;
    end

    // ==========================================
    // Register port and packet tasks
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1; exp_rd.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Heads are staged so that several inputs can be launched in one cycle
    task send(input int i, input logic [3:0] d, input logic [7:0] a);
        dest_n[4*i +: 4] = d;
        laddr_n[8*i +: 8] = a;
        pend[i] = 1'b1;
    endtask
    task launch;
        @(posedge clk);
        dest <= dest_n; laddr <= laddr_n; post <= pend;
        pend = '0;
        @(posedge clk);
        post <= '0;
    endtask
    task drain;
        int n;
        n = 0;
        while ((exp_grant.size() + exp_spill.size() != 0 || grant !== '0 || spill !== '0)
               && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n >= 500) chk_word("drain cycles", 32'd0, 32'(n));
    endtask
    task do_reset(input logic s);
        @(posedge clk);
        nrst <= 1'b0; strap <= s;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // Counter is cleared with the link down, then silence is watched for 40 cycles
    task watch(input logic [31:0] ctrl);
        @(posedge clk);
        run <= '0;
        wr_reg(`ROA_OFF_CTRL, ctrl);
        seen = '0;
        // Link 2 always receives; a random set of the upper links receives too
        rxm = 11'h004 | (11'($urandom) & 11'h7F0);
        for (int c = 0; c < 40; c++) begin
            @(posedge clk);
            run <= '1;
            rxd <= (c == 0) ? rxm : 11'h000;
            txc <= (c % 4 == 0) ? 11'h008 : 11'h000;
            #1 seen = seen | dis;
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h7787));
        nrst = 1'b0; strap = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = '0;
        dest = '0; laddr = '0; dest_n = '0; laddr_n = '0; post = '0; pend = '0;
        run = '1; own = 11'h00D; txc = '0; rxd = '0; len = 8'h01;
        bad_count = 0; comparisons = 0;
        do_reset(1'($urandom));
        rd_reg(`ROA_OFF_CTRL, {`ROA_TMO_RST, 14'h0000, ~strap, 1'b0});
        rd_reg(`ROA_OFF_PRIO, {24'h00_0000, `ROA_PRIO_RST});
        ua = {1'b1, 7'($urandom)};
        wr_reg(ua, $urandom);
        rd_reg(ua, 32'h0000_0000);
        rd_reg(`ROA_OFF_BUSY, 32'h0000_0000);
        // Pointer starts at 10: input 1 before 3, then 3 waits for the end
        send(1, 4'h7, 8'h34); send(3, 4'h7, 8'h34);
        exp_grant.push_back(4'h1); exp_grant.push_back(4'h3);
        launch(); drain();
        // High at the threshold first; low order resumes after 3 despite it
        send(5, 4'h7, 8'h40); send(2, 4'h7, 8'h34); send(4, 4'h7, 8'h3F);
        exp_grant.push_back(4'h5); exp_grant.push_back(4'h4);
        exp_grant.push_back(4'h2);
        launch(); drain();
        // After holder 2 the search wraps from 10 to 0
        send(0, 4'h7, 8'h10); send(10, 4'h7, 8'h10);
        exp_grant.push_back(4'hA); exp_grant.push_back(4'h0);
        launch(); drain();
        // Bad destination and self address are spilled; errors reach status and irq
        send(8, 4'h8, 8'h10); send(9, 4'hF, 8'h10);
        exp_spill.push_back(4'h8); exp_spill.push_back(4'h9);
        launch(); drain();
        rd_reg(`ROA_OFF_STAT, 32'h0018_0000);
        chk_word("irq masked", 32'h0, {31'h0, irq});
        wr_reg(`ROA_OFF_MASK, 32'h0010_0000);
        repeat (2) @(posedge clk);
        #1 chk_word("irq raised", 32'h1, {31'h0, irq});
        wr_reg(`ROA_OFF_STAT, 32'h0010_0000);
        repeat (2) @(posedge clk);
        #1 chk_word("irq cleared", 32'h0, {31'h0, irq});
        rd_reg(`ROA_OFF_STAT, 32'h0008_0000);
        // Stopped link with start-on-request: connect first, grant once running
        @(posedge clk);
        run <= 11'($urandom) & 11'h7BF;
        wr_reg(`ROA_OFF_CTRL, 32'hFFFF_0004);
        send(0, 4'h6, 8'h20);
        launch();
        repeat (4) @(posedge clk);
        #1 chk_word("connect", 32'h40, {21'h0, conn});
        exp_grant.push_back(4'h0);
        @(posedge clk);
        run <= '1;
        drain();
        own <= 11'($urandom) | 11'h00D;
        // Strap low gives silence enable; only owned silent links are dropped
        do_reset(1'b0);
        rd_reg(`ROA_OFF_CTRL, 32'hFFFF_0002);
        watch(32'h0008_0003);
        chk_word("disabled links", {21'h0, own & ~rxm & 11'h7F7}, {21'h0, seen});
        rd_reg(`ROA_OFF_STAT, {21'h0, own & ~rxm & 11'h7F7});
        watch(32'h0008_0002);
        chk_word("disabled links", 32'h0, {21'h0, seen});
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
